// >>> inc/rtu_pkg.sv
package rtu_pkg;

  // Register byte offsets
  localparam logic [7:0] RTU_CTRL_OFS   = 8'h00;
  localparam logic [7:0] RTU_THRESH_OFS = 8'h04;
  localparam logic [7:0] RTU_PRETRG_OFS = 8'h08;
  localparam logic [7:0] RTU_DECIM_OFS  = 8'h0C;
  localparam logic [7:0] RTU_LENGTH_OFS = 8'h10;
  localparam logic [7:0] RTU_CMD_OFS    = 8'h14;
  localparam logic [7:0] RTU_STATUS_OFS = 8'h18;
  localparam logic [7:0] RTU_COUNT_OFS  = 8'h1C;

  // Control and command field positions
  localparam int RTU_CTRL_COND_LSB = 0;
  localparam int RTU_CTRL_EDGE_BIT = 2;
  localparam int RTU_CMD_ARM_BIT   = 0;
  localparam int RTU_CMD_STOP_BIT  = 1;

  // Reset values and pretrigger percent limit
  localparam logic [1:0]  RTU_COND_RST   = 2'h0;
  localparam logic        RTU_EDGE_RST   = 1'b1;
  localparam logic [31:0] RTU_THRESH_RST = 32'h00000000;
  localparam logic [6:0]  RTU_PRETRG_RST = 7'h00;
  localparam logic [15:0] RTU_DECIM_RST  = 16'h0001;
  localparam logic [15:0] RTU_LENGTH_RST = 16'h03E8;
  localparam logic [6:0]  RTU_PCT_FULL   = 7'h64;

  // Timing: one drive sample each 1/16000 s at 100 MHz
  localparam int RTU_CLK_HZ        = 100_000_000;
  localparam int RTU_SAMPLE_HZ     = 16_000;
  localparam int RTU_SAMPLE_CYCLES = RTU_CLK_HZ / RTU_SAMPLE_HZ;

  typedef enum logic [1:0] {
    RTU_COND_IMMEDIATE = 2'b00,
    RTU_COND_NEXT_CMD  = 2'b01,
    RTU_COND_SOURCE    = 2'b10,
    RTU_COND_BOOLEAN   = 2'b11
  } rtu_cond_e;

  typedef enum logic [1:0] {
    RTU_ST_IDLE    = 2'b00,
    RTU_ST_ARMED   = 2'b01,
    RTU_ST_POST    = 2'b10,
    RTU_ST_DONE    = 2'b11
  } rtu_state_e;

  typedef struct packed {
    logic [31:0] value;
    logic        flag;
  } rtu_sample_s;

  typedef struct packed {
    logic        triggered;
    logic        done;
    logic        armed;
  } rtu_status_s;

endpackage : rtu_pkg

// >>> core/rtu_fifo.sv
`timescale 1ns/1ps
module rtu_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem_q[rd_q];

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : rtu_fifo

// >>> core/rtu_trigger.sv
// Behaviour
// (RL1) A two-bit start-condition code selects one of four start modes.
// (RL2) Code 0 starts recording as soon as the arm command is taken.
// (RL3) Code 1 starts on the next command after arming.
// (RL4) Code 2 starts when the source crosses the threshold as set.
// (RL5) Code 3 starts on the level of a one-bit source.
// (RL6) The pretrigger share of samples lies before the trigger instant.
// (RL7) The pretrigger share is ignored in immediate mode.
// (RL8) The threshold is used only in source mode, not in boolean mode.
// (RL9) Positive edge: previous below threshold, current at or above.
// (RL10) Negative edge: previous above threshold, current at or below.
// (RL11) With decimation N above 1 and pretrigger, evaluate every N samples.
// (RL12) With zero pretrigger, evaluate on every drive sample.
// (RL13) Boolean mode fires on 1 when positive, on 0 when negative.
// (RL14) Boolean mode is level sensitive and may fire at once on arming.
// (RL15) One base drive sample is produced every 1/16000 second.
// (RL16) Buffer while armed, then record the post-trigger count and stop.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module rtu_trigger #(
  parameter int SAMPLE_CYCLES = rtu_pkg::RTU_SAMPLE_CYCLES
) (
  // Clock and reset
  input  wire logic                 core_clk_in,
  input  wire logic                 arst_n_in,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Drive signals
  input  wire rtu_pkg::rtu_sample_s src_in,
  input  wire logic                 host_cmd_in,
  // Recorded stream and status
  output logic                      rec_valid_out,
  input  wire logic                 rec_ready_in,
  output rtu_pkg::rtu_sample_s      rec_data_out,
  output logic                      arm_recording_command_mark_out,
  output rtu_pkg::rtu_status_s      status_out
);
  import rtu_pkg::*;

  localparam int SCW = $clog2(SAMPLE_CYCLES);

  rtu_cond_e    cond_q;
  logic         edge_pos_q;
  logic [31:0]  thresh_q;
  logic [6:0]   pretrg_q;
  logic [15:0]  decim_q;
  logic [15:0]  length_q;
  rtu_state_e   state_q;
  logic [SCW-1:0] scnt_q;
  logic         tick;
  logic [15:0]  dcnt_q;
  logic         eval_tick;
  logic [31:0]  prev_q;
  logic         prev_ok_q;
  logic         hit;
  logic         fire;
  logic [15:0]  pre_cnt_q;
  logic [15:0]  post_cnt_q;
  logic [15:0]  pre_need;
  logic [15:0]  post_need;
  logic         arm_wr;
  logic         stop_wr;
  logic         bus_wr;
  logic         bus_rd;
  logic         push;
  logic         fifo_ready;
  logic         trig_seen_q;
  logic         mark_pend_q;
  logic [22:0]  pre_prod;
  logic         fifo_push;
  logic         fifo_take;

  // Single-cycle APB, no wait states
  assign pready  = 1'b1;
  assign bus_wr  = psel && penable && pwrite;
  assign bus_rd  = psel && penable && !pwrite;
  assign arm_wr  = bus_wr && (paddr == RTU_CMD_OFS) && pwdata[RTU_CMD_ARM_BIT];
  assign stop_wr = bus_wr && (paddr == RTU_CMD_OFS)
                   && pwdata[RTU_CMD_STOP_BIT];

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      unique case (paddr)
        RTU_CTRL_OFS, RTU_THRESH_OFS, RTU_PRETRG_OFS, RTU_DECIM_OFS,
        RTU_LENGTH_OFS, RTU_CMD_OFS, RTU_STATUS_OFS, RTU_COUNT_OFS: ;
        default: pslverr = 1'b1;
      endcase
    end
  end

  // Configuration cannot change under a running capture
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cond_q     <= rtu_cond_e'(RTU_COND_RST);
      edge_pos_q <= RTU_EDGE_RST;
      thresh_q   <= RTU_THRESH_RST;
      pretrg_q   <= RTU_PRETRG_RST;
      decim_q    <= RTU_DECIM_RST;
      length_q   <= RTU_LENGTH_RST;
    end else if (bus_wr && state_q != RTU_ST_ARMED
                 && state_q != RTU_ST_POST) begin
      unique case (paddr)
        // (RL1) Mode code select
        RTU_CTRL_OFS: begin
          cond_q     <= rtu_cond_e'(pwdata[RTU_CTRL_COND_LSB +: 2]);
          edge_pos_q <= pwdata[RTU_CTRL_EDGE_BIT];
        end
        RTU_THRESH_OFS: thresh_q <= pwdata;
        RTU_PRETRG_OFS: begin
          pretrg_q <= (pwdata[6:0] > RTU_PCT_FULL) ? RTU_PCT_FULL
                                                   : pwdata[6:0];
        end
        RTU_DECIM_OFS: begin
          decim_q <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        end
        RTU_LENGTH_OFS: begin
          length_q <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    prdata = 32'h00000000;
    if (bus_rd) begin
      unique case (paddr)
        RTU_CTRL_OFS:   prdata = {29'h0, edge_pos_q, cond_q};
        RTU_THRESH_OFS: prdata = thresh_q;
        RTU_PRETRG_OFS: prdata = {25'h0, pretrg_q};
        RTU_DECIM_OFS:  prdata = {16'h0, decim_q};
        RTU_LENGTH_OFS: prdata = {16'h0, length_q};
        RTU_STATUS_OFS: prdata = {29'h0, status_out};
        RTU_COUNT_OFS:  prdata = {16'h0, post_cnt_q};
        default:        prdata = 32'h00000000;
      endcase
    end
  end

  // (RL15) Base drive sample divider
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scnt_q <= '0;
    end else if (scnt_q == SCW'(SAMPLE_CYCLES-1)) begin
      scnt_q <= '0;
    end else begin
      scnt_q <= scnt_q + 1'b1;
    end
  end
  assign tick = (scnt_q == SCW'(SAMPLE_CYCLES-1));

  // Decimation phase restarts on each arm so records line up with it
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dcnt_q <= 16'h0000;
    end else if (arm_wr) begin
      dcnt_q <= 16'h0000;
    end else if (tick) begin
      dcnt_q <= (dcnt_q >= decim_q - 16'h0001) ? 16'h0000
                                               : dcnt_q + 16'h0001;
    end
  end

  // (RL11) Evaluate on decimated samples with pretrigger
  // (RL12) Zero pretrigger evaluates every sample
  assign eval_tick = tick && ((pretrg_q == 7'h00) || (dcnt_q == 16'h0000));
  assign push = tick && (dcnt_q == 16'h0000)
                && (state_q == RTU_ST_ARMED || state_q == RTU_ST_POST);

  // Previous evaluated source value
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_q    <= 32'h00000000;
      prev_ok_q <= 1'b0;
    end else if (arm_wr) begin
      prev_ok_q <= 1'b0;
    end else if (eval_tick && state_q == RTU_ST_ARMED) begin
      prev_q    <= src_in.value;
      prev_ok_q <= 1'b1;
    end
  end

  always_comb begin
    hit = 1'b0;
    unique case (cond_q)
      // (RL2) Immediate start
      RTU_COND_IMMEDIATE: hit = 1'b1;
      // (RL3) Next command start
      RTU_COND_NEXT_CMD:  hit = host_cmd_in;
      // (RL4) Source crossing start
      RTU_COND_SOURCE: begin
        if (edge_pos_q) begin
          // (RL9) Rising crossing test
          hit = prev_ok_q && ($signed(prev_q) < $signed(thresh_q))
                && ($signed(src_in.value) >= $signed(thresh_q));
        end else begin
          // (RL10) Falling crossing test
          hit = prev_ok_q && ($signed(prev_q) > $signed(thresh_q))
                && ($signed(src_in.value) <= $signed(thresh_q));
        end
      end
      // (RL5) Boolean level start
      // (RL8) Threshold unused here
      // (RL13) Polarity from edge
      // (RL14) Level, not transition
      RTU_COND_BOOLEAN: hit = (src_in.flag == edge_pos_q);
    endcase
  end

  // (RL6) Pretrigger sample share
  // (RL7) Immediate mode has none
  assign pre_prod  = 23'(length_q) * 23'(pretrg_q);
  assign pre_need  = (cond_q == RTU_COND_IMMEDIATE) ? 16'h0000
                     : 16'(pre_prod / 23'd100);
  assign post_need = length_q - pre_need;

  // Command-mode fires on the command itself; immediate mode on its first pushed sample; others on evaluation ticks
  assign fire = (state_q == RTU_ST_ARMED) && (pre_cnt_q >= pre_need)
                && ((cond_q == RTU_COND_NEXT_CMD) ? hit
                    : (cond_q == RTU_COND_IMMEDIATE) ? push
                    : (eval_tick && hit));

  // Immediate mode records nothing ahead of its trigger
  assign fifo_push = push && (state_q == RTU_ST_POST || fire
                     || cond_q != RTU_COND_IMMEDIATE);
  assign fifo_take = fifo_push && fifo_ready;

  // (RL16) Armed, post-trigger, done sequence
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= RTU_ST_IDLE;
    end else if (stop_wr) begin
      state_q <= RTU_ST_IDLE;
    end else if (arm_wr) begin
      state_q <= RTU_ST_ARMED;
    end else begin
      unique case (state_q)
        RTU_ST_IDLE:  ;
        RTU_ST_ARMED: if (fire) state_q <= RTU_ST_POST;
        RTU_ST_POST: begin
          if (post_cnt_q >= post_need) state_q <= RTU_ST_DONE;
        end
        RTU_ST_DONE:  ;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_cnt_q  <= 16'h0000;
      post_cnt_q <= 16'h0000;
    end else if (arm_wr) begin
      pre_cnt_q  <= 16'h0000;
      post_cnt_q <= 16'h0000;
    end else if (fifo_take) begin
      if (state_q == RTU_ST_POST || fire) begin
        post_cnt_q <= post_cnt_q + 16'h0001;
      end else if (pre_cnt_q < pre_need) begin
        pre_cnt_q <= pre_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trig_seen_q <= 1'b0;
      mark_pend_q <= 1'b0;
    end else if (arm_wr) begin
      trig_seen_q <= 1'b0;
      mark_pend_q <= 1'b0;
    end else if (fire) begin
      trig_seen_q <= 1'b1;
      // A mark already carried by this sample must not repeat
      mark_pend_q <= !fifo_take;
    end else if (fifo_take) begin
      mark_pend_q <= 1'b0;
    end
  end

  // Overflow drops the sample: a stalled sink loses data, not timing
  rtu_fifo #(
    .WIDTH ($bits(rtu_sample_s)+1),
    .DEPTH (4)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .arst_n_in     (arst_n_in),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_ready),
    .in_data_in    ({fire || mark_pend_q, src_in}),
    .out_valid_out (rec_valid_out),
    .out_ready_in  (rec_ready_in),
    .out_data_out  ({arm_recording_command_mark_out, rec_data_out})
  );

  assign status_out.armed     = (state_q == RTU_ST_ARMED);
  assign status_out.done      = (state_q == RTU_ST_DONE);
  assign status_out.triggered = trig_seen_q;

  a_boolean_level: assert property ( // (RL14)
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == RTU_ST_ARMED && cond_q == RTU_COND_BOOLEAN
     && src_in.flag == edge_pos_q && eval_tick && push
     && pre_cnt_q >= pre_need && !arm_wr && !stop_wr)
    |=> state_q == RTU_ST_POST)
    else $error("boolean level did not fire");

  a_rising_cross: assert property ( // (RL9)
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (fire && cond_q == RTU_COND_SOURCE && edge_pos_q)
    |-> $signed(src_in.value) >= $signed(thresh_q))
    else $error("rising trigger below threshold");

  a_falling_cross: assert property ( // (RL10)
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (fire && cond_q == RTU_COND_SOURCE && !edge_pos_q)
    |-> $signed(prev_q) > $signed(thresh_q))
    else $error("falling trigger without prior above");

  a_immediate_nopre: assert property ( // (RL7)
    @(posedge core_clk_in) disable iff (!arst_n_in)
    cond_q == RTU_COND_IMMEDIATE |-> pre_need == 16'h0000)
    else $error("pretrigger used in immediate mode");

  a_cmd_start: assert property ( // (RL3)
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == RTU_ST_ARMED && cond_q == RTU_COND_NEXT_CMD && host_cmd_in
     && pre_cnt_q >= pre_need && !arm_wr && !stop_wr)
    |=> state_q == RTU_ST_POST)
    else $error("command did not start recording");

  a_tick_period: assert property ( // (RL15)
    @(posedge core_clk_in) disable iff (!arst_n_in)
    tick |=> !tick [*5])
    else $error("drive sample too frequent");

  a_eval_every: assert property ( // (RL12)
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == RTU_ST_ARMED && tick && pretrg_q == 7'h00 && hit
     && (cond_q == RTU_COND_SOURCE || cond_q == RTU_COND_BOOLEAN)
     && pre_cnt_q >= pre_need && !arm_wr && !stop_wr)
    |=> state_q == RTU_ST_POST)
    else $error("sample skipped with zero pretrigger");

  a_eval_decim: assert property ( // (RL11)
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (fire && pretrg_q != 7'h00 && cond_q != RTU_COND_NEXT_CMD)
    |-> tick && dcnt_q == 16'h0000)
    else $error("trigger off decimation phase");

  a_post_stop: assert property ( // (RL16)
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == RTU_ST_POST && post_cnt_q >= post_need
     && !arm_wr && !stop_wr) |=> status_out.done)
    else $error("recording did not stop");

  // Arming restarts the capture; no trigger state may survive it
  sequence s_arm_taken;
    arm_wr && !stop_wr;
  endsequence

  sequence s_fresh_armed;
    status_out.armed && !status_out.triggered;
  endsequence

  a_arm_clears: assert property ( // (RL16)
    @(posedge core_clk_in) disable iff (!arst_n_in)
    s_arm_taken |=> s_fresh_armed)
    else $error("arming kept stale trigger state");

  sequence s_immediate_push;
    state_q == RTU_ST_ARMED && cond_q == RTU_COND_IMMEDIATE && push
    && !arm_wr && !stop_wr;
  endsequence

  a_immediate_start: assert property ( // (RL2)
    @(posedge core_clk_in) disable iff (!arst_n_in)
    s_immediate_push |=> state_q == RTU_ST_POST && status_out.triggered)
    else $error("immediate start did not begin recording");

endmodule : rtu_trigger

// >>> dv/rtu_host_model.sv
`timescale 1ns/1ps
module rtu_host_model (
  // Clock
  input  wire logic        core_clk_in,
  // APB master
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [7:0]       paddr_out,
  output logic [31:0]      pwdata_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  // Command channel
  output logic             host_cmd_out
);
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h00000000;
    host_cmd_out = 1'b0;
  end

  // A missing pready returns an unknown error flag so the caller flags it
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    int n;
    @(posedge core_clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge core_clk_in);
    penable_out <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 100);
    rd = prdata_in;
    err = (n < 100) ? pslverr_in : 1'bx;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask : xfer

  // One command arrives on the command channel
  task automatic cmd_pulse();
    @(posedge core_clk_in);
    host_cmd_out <= 1'b1;
    @(posedge core_clk_in);
    host_cmd_out <= 1'b0;
  endtask : cmd_pulse
endmodule : rtu_host_model

// >>> dv/recorder_trigger_unit_tb.sv
`timescale 1ns/1ps
module recorder_trigger_unit_tb;
  import rtu_pkg::*;
  localparam int SC = 8;
  localparam int LEN = 4;
  logic        core_clk_in, arst_n_in, psel, penable, pwrite;
  logic        pready, pslverr, host_cmd_in, rec_valid_out;
  logic        arm_recording_command_mark_out, rec_ready_in, src_flag;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, mark_val;
  logic [31:0] src_val = 32'h0;
  rtu_sample_s src_in, rec_data_out;
  rtu_status_s status_out;
  int          errors, samples_checked, pops_base, marks_base;
  int          pops = 0;
  int          marks = 0;
  int          mark_at = 0;
  int          tick_cnt = 0;

  assign src_in = '{value: src_val, flag: src_flag};

  rtu_host_model host (.core_clk_in(core_clk_in), .psel_out(psel),
    .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .host_cmd_out(host_cmd_in));

  rtu_trigger #(.SAMPLE_CYCLES(SC)) dut (.core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_in(src_in),
    .host_cmd_in(host_cmd_in), .rec_valid_out(rec_valid_out),
    .rec_ready_in(rec_ready_in), .rec_data_out(rec_data_out),
    .arm_recording_command_mark_out(arm_recording_command_mark_out), .status_out(status_out));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // Sawtooth 0..9, one step per drive sample
  always @(posedge core_clk_in) begin
    if (tick_cnt == SC - 1) begin
      tick_cnt <= 0;
      src_val <= (src_val == 32'h9) ? 32'h0 : src_val + 32'h1;
    end else begin
      tick_cnt <= tick_cnt + 1;
    end
  end

  always @(posedge core_clk_in) begin
    if (rec_valid_out === 1'b1 && rec_ready_in === 1'b1) begin
      pops <= pops + 1;
      if (arm_recording_command_mark_out === 1'b1) begin
        marks    <= marks + 1;
        mark_at  <= pops;
        mark_val <= rec_data_out.value;
      end
    end
  end

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    host.xfer(1'b1, a, d, rd, err);
    chk({31'h0, err}, 32'h0);
    if (err === 1'bx) test_done();
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] rd;
    logic        err;
    host.xfer(1'b0, a, 32'h0, rd, err);
    chk({31'h0, err}, {31'h0, exp_err});
    if (err === 1'bx) test_done();
    if (!exp_err) chk(rd, exp);
  endtask : rd_chk

  task automatic wait_stat(input int b, input int lim);
    int n;
    n = 0;
    while (status_out[b] !== 1'b1 && n < lim) begin
      @(posedge core_clk_in);
      n++;
    end
    samples_checked++;
    if (n >= lim) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, status_out, b);
      test_done();
    end
  endtask : wait_stat

  task automatic chk_trig(input logic exp);
    @(negedge core_clk_in);
    chk({31'h0, status_out.triggered}, {31'h0, exp});
  endtask : chk_trig

  task automatic arm(input logic [1:0] code, input logic edge_pos);
    wr(RTU_CMD_OFS, 32'h2);
    wr(RTU_CTRL_OFS, {29'h0, edge_pos, code});
    pops_base = pops;
    marks_base = marks;
    wr(RTU_CMD_OFS, 32'h1);
  endtask : arm

  task automatic t_reset();
    rd_chk(RTU_CTRL_OFS, {29'h0, RTU_EDGE_RST, RTU_COND_RST}, 1'b0);
    rd_chk(RTU_DECIM_OFS, 32'h1, 1'b0);
    rd_chk(RTU_LENGTH_OFS, 32'h3E8, 1'b0);
    rd_chk(8'h20, 32'h0, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_immediate();
    wr(RTU_LENGTH_OFS, LEN);
    wr(RTU_PRETRG_OFS, 32'd50);
    arm(RTU_COND_IMMEDIATE, 1'b1);
    wait_stat(2, 2 * SC + 8);
    wait_stat(1, 10 * SC);
    repeat (4) @(posedge core_clk_in);
    chk(pops - pops_base, LEN);
    chk(marks - marks_base, 32'h1);
    chk(mark_at - pops_base, 32'h0);
    $display("test immediate done");
  endtask : t_immediate

  task automatic t_next_cmd();
    wr(RTU_PRETRG_OFS, 32'h0);
    arm(RTU_COND_NEXT_CMD, 1'b1);
    // Configuration must stay frozen while a capture runs
    wr(RTU_LENGTH_OFS, 32'h7);
    rd_chk(RTU_LENGTH_OFS, 32'h4, 1'b0);
    repeat (4 * SC) @(posedge core_clk_in);
    chk_trig(1'b0);
    host.cmd_pulse();
    wait_stat(2, 8);
    // Stop wins over arm in one command word
    wr(RTU_CMD_OFS, 32'h3);
    @(negedge core_clk_in);
    chk({31'h0, status_out.armed}, 32'h0);
    $display("test next command done");
  endtask : t_next_cmd

  // A decimated record may mark the crossing sample or the one after it
  task automatic t_source(input logic pos, input int pct, input int dec,
                          input logic [31:0] exp);
    logic ok;
    wr(RTU_CMD_OFS, 32'h2);
    wr(RTU_THRESH_OFS, 32'h3);
    wr(RTU_PRETRG_OFS, pct);
    wr(RTU_DECIM_OFS, dec);
    arm(RTU_COND_SOURCE, pos);
    wait_stat(1, 40 * SC);
    repeat (4) @(posedge core_clk_in);
    chk(marks - marks_base, 32'h1);
    ok = (mark_val == exp) || (dec > 1 && mark_val == exp + 32'h1);
    chk({31'h0, ok}, 32'h1);
    ok = (mark_at - pops_base) >= (LEN * pct / 100);
    chk({31'h0, ok}, 32'h1);
    chk(pops - mark_at, LEN - LEN * pct / 100);
    $display("test source edge %0d pct %0d done", pos, pct);
  endtask : t_source

  task automatic t_bool();
    @(posedge core_clk_in);
    src_flag <= 1'b1;
    wr(RTU_CMD_OFS, 32'h2);
    wr(RTU_THRESH_OFS, 32'h7FFFFFFF);
    arm(RTU_COND_BOOLEAN, 1'b1);
    wait_stat(2, 2 * SC + 8);
    arm(RTU_COND_BOOLEAN, 1'b0);
    repeat (3 * SC) @(posedge core_clk_in);
    chk_trig(1'b0);
    @(posedge core_clk_in);
    src_flag <= 1'b0;
    wait_stat(2, 2 * SC + 8);
    $display("test boolean done");
  endtask : t_bool

  initial begin
    arst_n_in = 1'b0;
    rec_ready_in = 1'b1;
    src_flag = 1'b0;
    pops_base = 0;
    marks_base = 0;
    errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_immediate();
    t_next_cmd();
    t_source(1'b1, 0, 1, 32'h3);
    t_source(1'b1, 50, 2, 32'h3);
    t_source(1'b0, 0, 2, 32'h0);
    t_bool();
    test_done();
  end
endmodule : recorder_trigger_unit_tb
